/* logic/rail_sup_pkg.sv */
`default_nettype none
package rail_sup_pkg;
   localparam int CH_NUM = 4;
   localparam int TICK_NS = 1000;
   localparam int CLK_PERIOD_NS = 4;
   // one microsecond tick; 250 cycles at 250 MHz
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int OC_RESTART_MS = 200;
   localparam int OC_RESTART_US = OC_RESTART_MS * 1000;
   localparam int DLY_UNIT_US = 250;
   localparam int CNT_W = 18;
   // target code in 50 mV, monitor in 10 mV: factor 5
   localparam logic [3:0] TGT_TO_MON = 4'h5;
   localparam logic [7:0] HIGH_RANGE_CODE = 8'h32;
   localparam logic [5:0] OV_BASE_10MV = 6'h0f;
   localparam logic [5:0] OV_STEP_10MV = 6'h05;
   localparam logic [7:0] DISCHARGE_CODE = 8'h00;
   localparam int LIM_LSB = 0;
   localparam int LIM_W = 6;
   localparam int WARN_LSB = 6;
   localparam int DLY_LSB = 10;
   localparam int DLY_W = 6;
   localparam int STEP_W = 10;

   typedef struct packed {
      logic [7:0] target_code;       // output_target_code, 50 mV lsb
      logic [1:0] ov_select;         // overvoltage_threshold_select
      logic ov_forced;               // 1: hold low_side_gate_drive on
      logic [7:0] current_limit_and_warning;
      logic [15:0] ramp_up_timing;
      logic [15:0] ramp_down_timing;
      logic [7:0] good_window_upper; // 20 mV lsb
      logic [7:0] good_window_lower; // 20 mV lsb
      logic [7:0] good_assert_delay; // 250 us units
   } chan_cfg_s;

   typedef struct packed {
      logic [9:0] output_voltage_readback; // 10 mV lsb
      logic [6:0] current_sense;           // 5 mV lsb
   } chan_mon_s;

   typedef struct packed {
      logic [6:0] thermal_trip_level;    // 5 K lsb
      logic [6:0] thermal_restart_level; // 5 K lsb
      logic auto_restart;
   } chip_cfg_s;

   typedef enum logic [7:0] {
      ST_OFF = 8'h01,
      ST_START_DLY = 8'h02,
      ST_RAMP_UP = 8'h04,
      ST_ON = 8'h08,
      ST_STOP_DLY = 8'h10,
      ST_RAMP_DOWN = 8'h20,
      ST_OC_WAIT = 8'h40,
      ST_SPARE = 8'h80
   } chan_state_e;
endpackage
`default_nettype wire

/* logic/rail_fault_and_ramp_supervisor.sv */
// Contract
// - over-temperature sets fault and warning flags, stops all channels, bus stays alive
// - thermal trip level is seven bits, 5 K per step
// - optional automatic restart once temperature falls below restart level
// - target voltage equals target code times 50 mV
// - over-voltage watched always, even in soft-start; trip stops channel, sets flag; code skips the check while off and in over-current wait
// - over-voltage margin 150..300 mV, doubled above 2.5 V target
// - over-voltage trip also disables every follower of the faulted channel
// - over-voltage-stopped channels stay off until host enables them again; code lets a leader's over-current restart a stopped follower
// - any fault or warning can drive a general-purpose alert pin
// - per channel passive or forced over-voltage shutdown; forced holds low-side drive on
// - limit bits 5..0 set over-current threshold, 5 mV steps, 0..315 mV
// - limit bits 7..6 set warning 10..40 mV below limit
// - over-current warning flag clears itself once current drops
// - over-current stops pulses, waits 200 ms, restarts through soft-start
// - over-current also restarts followers and flags them
// - ramp-up bits 15..10 give start delay in 250 us units
// - ramp-up bits 9..0 give microseconds per 50 mV step
// - host disable: delay in 250 us units, then ramp down to discharge level
// - power-good high while output within upper and lower bounds, 20 mV lsb
// - power-good waits for soft-start end plus programmable delay
`timescale 1ns/100ps
`default_nettype none
module rail_fault_and_ramp_supervisor #(
   parameter int CHANNELS = rail_sup_pkg::CH_NUM,
   parameter int OC_RESTART_US = rail_sup_pkg::OC_RESTART_US,
   parameter int TICK_CYCLES = rail_sup_pkg::TICK_CYCLES
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [CHANNELS-1:0] CH_ENABLE,
   input wire rail_sup_pkg::chan_cfg_s [CHANNELS-1:0] CH_CFG,
   input wire rail_sup_pkg::chan_mon_s [CHANNELS-1:0] CH_MON,
   input wire rail_sup_pkg::chip_cfg_s CHIP_CFG,
   input wire logic [6:0] TEMP_READING,
   input wire logic [7:0] FOLLOWER_MAP_LOW,
   input wire logic [7:0] FOLLOWER_MAP_HIGH,
   input wire logic [13:0] ALERT_SELECT,
   input wire logic FLAG_CLEAR,
   output logic [CHANNELS-1:0] PULSE_ENABLE,
   output logic [CHANNELS-1:0] LOW_SIDE_GATE_DRIVE,
   output logic [CHANNELS-1:0][7:0] RAMP_REF_CODE,
   output logic [CHANNELS-1:0] POWER_GOOD,
   output logic OVER_TEMP_FAULT,
   output logic OVER_TEMP_WARNING_FLAG,
   output logic [CHANNELS-1:0] OVER_VOLTAGE_FAULT,
   output logic [CHANNELS-1:0] OVER_CURRENT_FAULT,
   output logic [CHANNELS-1:0] OVERCURRENT_WARNING_STATUS,
   output logic ALERT_PIN
);
   localparam int CW = rail_sup_pkg::CNT_W;

   if (CHANNELS != 4) begin : g_bad_channels
      $error("follower map serves exactly four channels");
   end
   if (OC_RESTART_US < 1 || OC_RESTART_US >= (1 << CW)) begin : g_bad_restart
      $error("restart time does not fit the channel counter");
   end
   if (TICK_CYCLES < 1 || TICK_CYCLES > 4096) begin : g_bad_tick
      $error("tick divider out of range");
   end

   // microsecond tick shared by all channel timers
   logic [12:0] div_ff;
   logic tick_ff;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         div_ff <= '0;
         tick_ff <= 1'b0;
      end else if (div_ff == 13'(TICK_CYCLES - 1)) begin
         div_ff <= '0;
         tick_ff <= 1'b1;
      end else begin
         div_ff <= div_ff + 13'h1;
         tick_ff <= 1'b0;
      end
   end

   // over-temperature with hysteresis toward the restart level
   logic ot_ff;
   logic ot_latched_ff;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ot_ff <= 1'b0;
      end else if (TEMP_READING >= CHIP_CFG.thermal_trip_level) begin
         ot_ff <= 1'b1;
      end else if (TEMP_READING < CHIP_CFG.thermal_restart_level) begin
         ot_ff <= 1'b0;
      end
   end
   // without auto restart the chip stays down until every channel enable has dropped low and channels are re-enabled
   wire ot_release = ~ot_ff & ~ot_latched_ff;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ot_latched_ff <= 1'b0;
      end else if (ot_ff && !CHIP_CFG.auto_restart) begin
         ot_latched_ff <= 1'b1;
      end else if (CHIP_CFG.auto_restart || CH_ENABLE == '0) begin
         ot_latched_ff <= 1'b0;
      end
   end

   logic [CHANNELS-1:0] ov_trip;
   logic [CHANNELS-1:0] oc_trip;
   logic [CHANNELS-1:0] ov_kill;
   logic [CHANNELS-1:0] oc_kick;
   logic [CHANNELS-1:0] oc_warn;
   wire [15:0] follow_map = {FOLLOWER_MAP_HIGH, FOLLOWER_MAP_LOW};

   // row j of the map lists the followers of channel j
   always_comb begin
      ov_kill = ov_trip;
      oc_kick = oc_trip;
      for (int j = 0; j < CHANNELS; j++) begin
         for (int k = 0; k < CHANNELS; k++) begin
            if (ov_trip[j] && follow_map[j*4+k]) ov_kill[k] = 1'b1;
            if (oc_trip[j] && follow_map[j*4+k]) oc_kick[k] = 1'b1;
         end
      end
   end

   for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
      rail_sup_pkg::chan_state_e st_ff;
      rail_sup_pkg::chan_state_e nxt_st;
      logic [CW-1:0] cnt_ff;
      logic [CW-1:0] nxt_cnt;
      logic [CW-1:0] pg_cnt_ff;
      logic [7:0] ref_ff;
      logic [7:0] nxt_ref;
      logic lock_ff;
      logic [9:0] tgt_mon;
      logic [9:0] ov_level;
      logic [5:0] ov_margin;
      logic [7:0] warn_level;
      logic active;
      logic in_window;
      rail_sup_pkg::chan_cfg_s cfg;
      rail_sup_pkg::chan_mon_s mon;

      assign cfg = CH_CFG[i];
      assign mon = CH_MON[i];
      assign tgt_mon = 10'(cfg.target_code * rail_sup_pkg::TGT_TO_MON);
      // margin doubles for targets above 2.5 V
      assign ov_margin = 6'(rail_sup_pkg::OV_BASE_10MV
                            + cfg.ov_select * rail_sup_pkg::OV_STEP_10MV);
      assign ov_level = (cfg.target_code > rail_sup_pkg::HIGH_RANGE_CODE) ?
                        10'(tgt_mon + {ov_margin, 1'b0}) : 10'(tgt_mon + ov_margin);
      assign active = (st_ff != rail_sup_pkg::ST_OFF) && (st_ff != rail_sup_pkg::ST_OC_WAIT);
      // watched in every active state, soft-start included
      assign ov_trip[i] = active && (mon.output_voltage_readback >= ov_level);
      assign oc_trip[i] = active && ({1'b0, mon.current_sense} > {2'b00,
         cfg.current_limit_and_warning[rail_sup_pkg::LIM_LSB +: rail_sup_pkg::LIM_W]});
      assign warn_level = 8'({2'b00, cfg.current_limit_and_warning[
                            rail_sup_pkg::LIM_LSB +: rail_sup_pkg::LIM_W]})
         - 8'({cfg.current_limit_and_warning[rail_sup_pkg::WARN_LSB +: 2], 1'b0} + 3'h2);
      assign oc_warn[i] = ~warn_level[7] && ({1'b0, mon.current_sense} >= warn_level);
      assign in_window = (mon.output_voltage_readback <= {1'b0, cfg.good_window_upper, 1'b0})
         && (mon.output_voltage_readback >= {1'b0, cfg.good_window_lower, 1'b0});

      wire start_ok = CH_ENABLE[i] && !lock_ff && ot_release;
      wire [CW-1:0] up_dly = CW'(cfg.ramp_up_timing[rail_sup_pkg::DLY_LSB +:
                             rail_sup_pkg::DLY_W] * rail_sup_pkg::DLY_UNIT_US);
      wire [CW-1:0] dn_dly = CW'(cfg.ramp_down_timing[rail_sup_pkg::DLY_LSB +:
                             rail_sup_pkg::DLY_W] * rail_sup_pkg::DLY_UNIT_US);
      wire [CW-1:0] up_step = CW'(cfg.ramp_up_timing[rail_sup_pkg::STEP_W-1:0]);
      wire [CW-1:0] dn_step = CW'(cfg.ramp_down_timing[rail_sup_pkg::STEP_W-1:0]);
      // a load of n expires on the n-th tick, so a field of n lasts n us
      wire expired = tick_ff && (cnt_ff <= CW'(1));

      always_comb begin
         nxt_st = st_ff;
         nxt_cnt = (tick_ff && cnt_ff != '0) ? cnt_ff - CW'(1) : cnt_ff;
         nxt_ref = ref_ff;
         if (ov_kill[i] || ot_ff) begin
            nxt_st = rail_sup_pkg::ST_OFF;
         end else if (oc_kick[i]) begin
            nxt_st = rail_sup_pkg::ST_OC_WAIT;
            nxt_cnt = CW'(OC_RESTART_US);
            nxt_ref = '0;
         end else begin
            case (st_ff)
               rail_sup_pkg::ST_OFF: begin
                  if (start_ok) begin
                     nxt_st = rail_sup_pkg::ST_START_DLY;
                     nxt_cnt = up_dly;
                  end
               end
               rail_sup_pkg::ST_START_DLY: begin
                  if (!CH_ENABLE[i]) begin
                     nxt_st = rail_sup_pkg::ST_OFF;
                  end else if (expired) begin
                     nxt_st = rail_sup_pkg::ST_RAMP_UP;
                     nxt_cnt = up_step;
                     nxt_ref = '0;
                  end
               end
               rail_sup_pkg::ST_RAMP_UP: begin
                  if (!CH_ENABLE[i]) begin
                     nxt_st = rail_sup_pkg::ST_STOP_DLY;
                     nxt_cnt = dn_dly;
                  end else if (ref_ff >= cfg.target_code) begin
                     nxt_st = rail_sup_pkg::ST_ON;
                     nxt_ref = cfg.target_code;
                  end else if (expired) begin
                     nxt_ref = ref_ff + 8'h1;
                     nxt_cnt = up_step;
                  end
               end
               rail_sup_pkg::ST_ON: begin
                  nxt_ref = cfg.target_code;
                  if (!CH_ENABLE[i]) begin
                     nxt_st = rail_sup_pkg::ST_STOP_DLY;
                     nxt_cnt = dn_dly;
                  end
               end
               rail_sup_pkg::ST_STOP_DLY: begin
                  if (expired) begin
                     nxt_st = rail_sup_pkg::ST_RAMP_DOWN;
                     nxt_cnt = dn_step;
                  end
               end
               rail_sup_pkg::ST_RAMP_DOWN: begin
                  if (ref_ff <= rail_sup_pkg::DISCHARGE_CODE) begin
                     nxt_st = rail_sup_pkg::ST_OFF;
                  end else if (expired) begin
                     nxt_ref = ref_ff - 8'h1;
                     nxt_cnt = dn_step;
                  end
               end
               rail_sup_pkg::ST_OC_WAIT: begin
                  if (!CH_ENABLE[i]) begin
                     nxt_st = rail_sup_pkg::ST_OFF;
                  end else if (expired) begin
                     nxt_st = rail_sup_pkg::ST_START_DLY;
                     nxt_cnt = up_dly;
                  end
               end
               default: nxt_st = rail_sup_pkg::ST_OFF;
            endcase
         end
         if (nxt_st == rail_sup_pkg::ST_OFF) begin
            nxt_cnt = '0;
            nxt_ref = '0;
         end
      end

      always_ff @(posedge CLK) begin
         if (!RST_N) begin
            st_ff <= rail_sup_pkg::ST_OFF;
            cnt_ff <= '0;
            ref_ff <= '0;
         end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            ref_ff <= nxt_ref;
         end
      end

      // lock keeps an over-voltage-stopped channel in ST_OFF until the host drops and raises enable; a leader's over-current kick still restarts it
      always_ff @(posedge CLK) begin
         if (!RST_N) begin
            lock_ff <= 1'b0;
         end else if (ov_kill[i]) begin
            lock_ff <= 1'b1;
         end else if (!CH_ENABLE[i]) begin
            lock_ff <= 1'b0;
         end
      end

      always_ff @(posedge CLK) begin
         if (!RST_N) begin
            LOW_SIDE_GATE_DRIVE[i] <= 1'b0;
         end else if (ov_kill[i] && cfg.ov_forced) begin
            LOW_SIDE_GATE_DRIVE[i] <= 1'b1;
         end else if (st_ff == rail_sup_pkg::ST_START_DLY) begin
            LOW_SIDE_GATE_DRIVE[i] <= 1'b0;
         end
      end

      // power-good delay starts only once the ramp has finished
      always_ff @(posedge CLK) begin
         if (!RST_N || st_ff != rail_sup_pkg::ST_ON) begin
            pg_cnt_ff <= CW'(cfg.good_assert_delay * rail_sup_pkg::DLY_UNIT_US);
            POWER_GOOD[i] <= 1'b0;
         end else begin
            if (tick_ff && pg_cnt_ff != '0) pg_cnt_ff <= pg_cnt_ff - CW'(1);
            POWER_GOOD[i] <= (pg_cnt_ff == '0) && in_window;
         end
      end

      always_ff @(posedge CLK) begin
         if (!RST_N) begin
            PULSE_ENABLE[i] <= 1'b0;
            RAMP_REF_CODE[i] <= '0;
         end else begin
            PULSE_ENABLE[i] <= (nxt_st == rail_sup_pkg::ST_RAMP_UP)
               || (nxt_st == rail_sup_pkg::ST_ON) || (nxt_st == rail_sup_pkg::ST_STOP_DLY)
               || (nxt_st == rail_sup_pkg::ST_RAMP_DOWN);
            RAMP_REF_CODE[i] <= nxt_ref;
         end
      end
   end

   // sticky flags: a new event in the clear cycle wins
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         OVER_TEMP_FAULT <= 1'b0;
         OVER_TEMP_WARNING_FLAG <= 1'b0;
         OVER_VOLTAGE_FAULT <= '0;
         OVER_CURRENT_FAULT <= '0;
      end else begin
         OVER_TEMP_FAULT <= ot_ff | (OVER_TEMP_FAULT & ~FLAG_CLEAR);
         OVER_TEMP_WARNING_FLAG <= ot_ff | (OVER_TEMP_WARNING_FLAG & ~FLAG_CLEAR);
         OVER_VOLTAGE_FAULT <= ov_kill | (OVER_VOLTAGE_FAULT & ~{CHANNELS{FLAG_CLEAR}});
         OVER_CURRENT_FAULT <= oc_kick | (OVER_CURRENT_FAULT & ~{CHANNELS{FLAG_CLEAR}});
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         OVERCURRENT_WARNING_STATUS <= '0;
      end else begin
         OVERCURRENT_WARNING_STATUS <= oc_warn;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ALERT_PIN <= 1'b0;
      end else begin
         ALERT_PIN <= |(ALERT_SELECT & {OVERCURRENT_WARNING_STATUS, OVER_CURRENT_FAULT,
            OVER_VOLTAGE_FAULT, OVER_TEMP_WARNING_FLAG, OVER_TEMP_FAULT});
      end
   end
endmodule
`default_nettype wire

/* test/rail_sup_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module rail_sup_chk #(
   parameter int CHANNELS = rail_sup_pkg::CH_NUM,
   parameter int OC_RESTART_US = rail_sup_pkg::OC_RESTART_US,
   parameter int TICK_CYCLES = rail_sup_pkg::TICK_CYCLES
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire rail_sup_pkg::chan_cfg_s [CHANNELS-1:0] CH_CFG,
   input wire rail_sup_pkg::chan_mon_s [CHANNELS-1:0] CH_MON,
   input wire rail_sup_pkg::chip_cfg_s CHIP_CFG,
   input wire logic [6:0] TEMP_READING,
   input wire logic [13:0] ALERT_SELECT,
   input wire logic [CHANNELS-1:0] PULSE_ENABLE,
   input wire logic [CHANNELS-1:0] LOW_SIDE_GATE_DRIVE,
   input wire logic [CHANNELS-1:0][7:0] RAMP_REF_CODE,
   input wire logic [CHANNELS-1:0] POWER_GOOD,
   input wire logic OVER_TEMP_FAULT,
   input wire logic OVER_TEMP_WARNING_FLAG,
   input wire logic [CHANNELS-1:0] OVER_VOLTAGE_FAULT,
   input wire logic [CHANNELS-1:0] OVER_CURRENT_FAULT,
   input wire logic [CHANNELS-1:0] OVERCURRENT_WARNING_STATUS,
   input wire logic ALERT_PIN
);
   logic [13:0] flags_now;
   assign flags_now = {OVERCURRENT_WARNING_STATUS, OVER_CURRENT_FAULT, OVER_VOLTAGE_FAULT,
      OVER_TEMP_WARNING_FLAG, OVER_TEMP_FAULT};
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   property p_ot_warn;
      $rose(OVER_TEMP_FAULT) |-> OVER_TEMP_WARNING_FLAG;
   endproperty
   a_ot_warn: assert property (p_ot_warn) else $error("no warning flag on thermal trip");
   property p_ot_stop;
      (TEMP_READING > CHIP_CFG.thermal_trip_level) [*3] |-> PULSE_ENABLE == '0;
   endproperty
   a_ot_stop: assert property (p_ot_stop) else $error("pulses while over temperature");
   property p_ov_stop;
      |(OVER_VOLTAGE_FAULT & ~$past(OVER_VOLTAGE_FAULT))
         |-> (PULSE_ENABLE & OVER_VOLTAGE_FAULT & ~$past(OVER_VOLTAGE_FAULT)) == '0;
   endproperty
   a_ov_stop: assert property (p_ov_stop) else $error("tripped channel still pulsing");
   property p_lsd_excl;
      (LOW_SIDE_GATE_DRIVE & PULSE_ENABLE) == '0;
   endproperty
   a_lsd_excl: assert property (p_lsd_excl) else $error("forced drive during pulses");
   property p_oc_hold;
      $rose(OVER_CURRENT_FAULT[0]) |-> (!PULSE_ENABLE[0]) [*8];
   endproperty
   a_oc_hold: assert property (p_oc_hold) else $error("pulses during restart wait");
   property p_ocw_clear;
      ({1'b0, $past(CH_MON[0].current_sense)}
         + {5'h00, $past(CH_CFG[0].current_limit_and_warning[7:6]), 1'b0}
         + 8'h02 < {2'h0, $past(CH_CFG[0].current_limit_and_warning[5:0])})
         |-> !OVERCURRENT_WARNING_STATUS[0];
   endproperty
   a_ocw_clear: assert property (p_ocw_clear) else $error("current warning not cleared");
   property p_ref_step;
      PULSE_ENABLE[0] && $past(PULSE_ENABLE[0])
         |-> 8'(RAMP_REF_CODE[0] - $past(RAMP_REF_CODE[0]) + 8'h01) <= 8'h02;
   endproperty
   a_ref_step: assert property (p_ref_step) else $error("reference jumped");
   property p_ref_cap;
      PULSE_ENABLE[0] |-> RAMP_REF_CODE[0] <= CH_CFG[0].target_code;
   endproperty
   a_ref_cap: assert property (p_ref_cap) else $error("reference above target");
   property p_pg_win;
      POWER_GOOD[0] |-> $past(CH_MON[0].output_voltage_readback) >=
         {1'b0, $past(CH_CFG[0].good_window_lower), 1'b0}
         && $past(CH_MON[0].output_voltage_readback)
         <= {1'b0, $past(CH_CFG[0].good_window_upper), 1'b0};
   endproperty
   a_pg_win: assert property (p_pg_win) else $error("power good outside window");
   property p_alert;
      ALERT_PIN == |($past(flags_now) & $past(ALERT_SELECT));
   endproperty
   a_alert: assert property (p_alert) else $error("alert pin mismatch");
endmodule
bind rail_fault_and_ramp_supervisor rail_sup_chk #(.CHANNELS(CHANNELS),
   .OC_RESTART_US(OC_RESTART_US), .TICK_CYCLES(TICK_CYCLES)) u_chk (.CLK(CLK), .RST_N(RST_N),
   .CH_CFG(CH_CFG), .CH_MON(CH_MON), .CHIP_CFG(CHIP_CFG), .TEMP_READING(TEMP_READING),
   .ALERT_SELECT(ALERT_SELECT), .PULSE_ENABLE(PULSE_ENABLE),
   .LOW_SIDE_GATE_DRIVE(LOW_SIDE_GATE_DRIVE), .RAMP_REF_CODE(RAMP_REF_CODE),
   .POWER_GOOD(POWER_GOOD), .OVER_TEMP_FAULT(OVER_TEMP_FAULT),
   .OVER_TEMP_WARNING_FLAG(OVER_TEMP_WARNING_FLAG), .OVER_VOLTAGE_FAULT(OVER_VOLTAGE_FAULT),
   .OVER_CURRENT_FAULT(OVER_CURRENT_FAULT),
   .OVERCURRENT_WARNING_STATUS(OVERCURRENT_WARNING_STATUS), .ALERT_PIN(ALERT_PIN));
`default_nettype wire

/* test/power_stage_model.sv */
`timescale 1ns/100ps
`default_nettype none
module power_stage_model (
   input wire logic clk,
   input wire logic [3:0] pulse_enable,
   input wire logic [3:0] low_side_gate_drive,
   input wire logic [3:0][7:0] ramp_ref_code,
   input wire logic [3:0][5:0] ov_bump,
   input wire logic [3:0][6:0] load_sense,
   output rail_sup_pkg::chan_mon_s [3:0] ch_mon
);
   initial ch_mon = '0;
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (pulse_enable[i]) begin
            ch_mon[i].output_voltage_readback <= 10'(ramp_ref_code[i]) * 10'h005 + 10'(ov_bump[i]);
            ch_mon[i].current_sense <= load_sense[i];
         end else begin
            // no switching, no inductor current to sense
            ch_mon[i].current_sense <= 7'h00;
            // forced low side clamps at once; passive stop only bleeds slowly
            if (low_side_gate_drive[i] || ch_mon[i].output_voltage_readback == 10'h000) begin
               ch_mon[i].output_voltage_readback <= 10'h000;
            end else begin
               ch_mon[i].output_voltage_readback <= ch_mon[i].output_voltage_readback - 10'h001;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* test/rail_fault_and_ramp_supervisor_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module rail_fault_and_ramp_supervisor_bench;
   logic clk, rst_n, flag_clear, otf, otw, alert;
   logic [3:0] ch_enable, pulse, lsd, pg, ovf, ocf, ocw;
   logic [3:0][7:0] ref_code;
   logic [3:0][5:0] bump;
   logic [3:0][6:0] load;
   logic [6:0] temp;
   logic [7:0] fmap_lo, fmap_hi;
   logic [13:0] alert_sel;
   rail_sup_pkg::chan_cfg_s [3:0] ch_cfg;
   rail_sup_pkg::chan_mon_s [3:0] ch_mon;
   rail_sup_pkg::chip_cfg_s chip_cfg;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   int n;
   rail_fault_and_ramp_supervisor #(.CHANNELS(4), .OC_RESTART_US(50), .TICK_CYCLES(2)) u_dut (
      .CLK(clk), .RST_N(rst_n), .CH_ENABLE(ch_enable), .CH_CFG(ch_cfg), .CH_MON(ch_mon),
      .CHIP_CFG(chip_cfg), .TEMP_READING(temp), .FOLLOWER_MAP_LOW(fmap_lo),
      .FOLLOWER_MAP_HIGH(fmap_hi), .ALERT_SELECT(alert_sel), .FLAG_CLEAR(flag_clear),
      .PULSE_ENABLE(pulse), .LOW_SIDE_GATE_DRIVE(lsd), .RAMP_REF_CODE(ref_code),
      .POWER_GOOD(pg), .OVER_TEMP_FAULT(otf), .OVER_TEMP_WARNING_FLAG(otw),
      .OVER_VOLTAGE_FAULT(ovf), .OVER_CURRENT_FAULT(ocf), .OVERCURRENT_WARNING_STATUS(ocw),
      .ALERT_PIN(alert));
   power_stage_model u_stage (.clk(clk), .pulse_enable(pulse), .low_side_gate_drive(lsd),
      .ramp_ref_code(ref_code), .ov_bump(bump), .load_sense(load), .ch_mon(ch_mon));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // 20000 cycles is about four times the planned sequence
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_pulse(input int ch, input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while (pulse[ch] !== lvl && cnt < lim) begin
         @(negedge clk);
         cnt++;
      end
      chk(pulse[ch], lvl);
   endtask
   task automatic idle(input int k);
      repeat (k) @(negedge clk);
   endtask
   initial begin
      rst_n = 1'b0;
      ch_enable = 4'h0;
      flag_clear = 1'b0;
      temp = 7'h30;
      fmap_lo = 8'h02; // channel 1 follows channel 0
      fmap_hi = 8'h08; // channel 3 follows channel 2
      alert_sel = 14'h0010;
      chip_cfg = '{7'h50, 7'h48, 1'b1};
      bump = '0;
      load = '0;
      for (int i = 0; i < 4; i++) begin
         ch_cfg[i] = '{8'h14, 2'h0, 1'b0, 8'h54, 16'h0401, 16'h0400, 8'h34, 8'h30, 8'h01};
      end
      ch_cfg[1].ov_select = 2'h3;
      ch_cfg[2].ov_forced = 1'b1;
      ch_cfg[3].target_code = 8'h32;
      idle(2);
      rst_n = 1'b1;
      ch_enable = 4'h3;
      wait_pulse(0, 1'b1, 700, n);
      chk(n >= 498 && n <= 506, 1);
      n = 0;
      while (ref_code[0] !== 8'h14 && n < 200) begin
         @(negedge clk);
         n++;
      end
      chk(n >= 38 && n <= 42, 1);
      idle(20);
      chk(ref_code[0], 8'h14);
      idle(400);
      chk(pg[0], 1'b0);
      idle(150);
      chk(pg[0], 1'b1);
      $display("test start_ramp_good done");
      load[0] = 7'd17;
      idle(4);
      chk({ocw[0], ocf[0]}, 2'h2);
      load[0] = 7'd15;
      idle(4);
      chk(ocw[0], 1'b0);
      load[0] = 7'd21;
      idle(4);
      chk({ocf[1:0], pulse[1:0]}, 4'hc);
      load[0] = 7'd0;
      idle(80);
      chk(pulse[1:0], 2'h0);
      wait_pulse(0, 1'b1, 800, n);
      chk(n >= 500 && n <= 540, 1);
      chk(pulse[1], 1'b1);
      $display("test overcurrent done");
      ch_enable = 4'hf;
      wait_pulse(2, 1'b1, 700, n);
      bump[2] = 6'h3f;
      idle(60);
      chk({ovf[3:2], pulse[3:2], lsd[3:2]}, 6'h31);
      chk(alert, 1'b1);
      bump[2] = 6'h00;
      idle(800);
      chk({pulse[3:2], lsd[2]}, 3'h1);
      ch_enable = 4'h3;
      idle(2);
      flag_clear = 1'b1;
      idle(1);
      flag_clear = 1'b0;
      idle(3);
      chk({ovf, alert}, 5'h00);
      ch_enable = 4'hf;
      wait_pulse(2, 1'b1, 700, n);
      chk(lsd[2], 1'b0);
      $display("test overvoltage done");
      bump[1] = 6'd25;
      idle(10);
      chk(ovf[1], 1'b0);
      bump[1] = 6'd35;
      idle(10);
      chk(ovf[1], 1'b1);
      bump[1] = 6'd0;
      ch_enable = 4'hd;
      idle(2);
      ch_enable = 4'hf;
      $display("test threshold done");
      idle(1);
      ch_enable = 4'he;
      idle(400);
      chk({pulse[0], ref_code[0]}, 9'h114);
      wait_pulse(0, 1'b0, 300, n);
      chk(n >= 125 && n <= 160, 1);
      chk(ref_code[0], 8'h00);
      $display("test soft_stop done");
      temp = 7'h4f;
      idle(5);
      chk(otf, 1'b0);
      temp = 7'h51;
      idle(5);
      chk({otf, otw, pulse}, 6'h30);
      temp = 7'h40;
      wait_pulse(2, 1'b1, 800, n);
      $display("test thermal done");
      report_and_stop();
   end
endmodule
`default_nettype wire
